//--- design/stal_ctrl.sv
// Purpose: upper two bits of the global s/t control register and the loopback 2 data path it steers
// Assumes: line-side status inputs are pins and pass two flip-flops; bus signals are mclk-synchronous
// Notes: lower six bits are plain storage; see stal_pkg for the map
//
// Notes on behaviour
// [RL1] loopback act select bit decides transmitted act bit during loopback 2
// [RL2] auto maintenance loopback set: loopback 2 entered on request by itself
// [RL3] without auto loopback software clears transparent loopback control to loop
// [RL4] loopback 2 routes s/t transmitter output into s/t receiver input
// [RL5] during loopback 2 terminal equipment signals are ignored
// [RL6] during loopback 2 device syncs to own signal and reports info 3
// [RL7] loopback act select loaded from act strap pin when reset releases
// [RL8] select 0: act bit 0 and data looped to lt at once
// [RL9] select 1: act bit 1 only after info 3 recognised
// [RL10] select 1: no data loop to lt before act 1 from lt
// [RL11] select 1: all-ones 2b+d toward lt until loop released; code sends all-ones only until act 1 from lt is seen
// [RL12] writing st only activation 0 with u inactive starts s/t-only activation
// [RL13] st only activation ignored while u-interface active
// [RL14] u tone, info1 or info3 sets st only activation back to 1
// [RL15] auto activation falling from 1 to 0 sets st only activation to 1
// [RL16] st only activation 1 changes nothing and reads 1 after reset
// [RL17] hardware set of st only activation beats a same-cycle software clear
`timescale 1ns/1ps
module stal_ctrl (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic act_strap_pin,
    input wire logic auto_maint_loopback,
    input wire logic transparent_loopback_ctrl,
    input wire logic auto_activation,
    input wire logic loopback_request,
    input wire logic u_active,
    input wire logic u_tone_rx,
    input wire logic info1_rx,
    input wire logic info3_rx,
    input wire logic lt_act_rx,
    input wire logic st_tx_line,
    input wire logic st_rx_line,
    input wire logic [7:0] u_rx_data,
    input wire logic [7:0] st_rx_data,
    output logic st_rx_to_core,
    output logic info3_report,
    output logic loopback2_active,
    output logic act_bit_tx,
    output logic [7:0] u_tx_data,
    output logic st_only_act_req,
    output logic [5:0] ctrl_low_bits
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [1:0] strap_s;
        logic [1:0] amb_s;
        logic [1:0] tlc_s;
        logic [1:0] aact_s;
        logic [1:0] req_s;
        logic [1:0] uact_s;
        logic [1:0] tone_s;
        logic [1:0] i1_s;
        logic [1:0] i3_s;
        logic [1:0] ltact_s;
        logic aact_d;
        logic strap_pending;
        logic act_sel;
        logic st_only;
        logic [5:0] low;
        logic info3_seen;
        logic lt_act_seen;
        logic act_tx;
        logic loop_on;
        logic [7:0] utx;
        logic ack;
        logic [31:0] rdata;
    } stal_state_t;

    stal_state_t s_reg;
    stal_state_t s_next;
    logic acc;
    logic wr_ctrl;
    logic hw_set;
    logic loop_entered;
    logic release_loop;

    // ==========================================================
    // combinational
    always_comb begin
        s_next = s_reg;
        // two-flop synchronisers for pin inputs
        s_next.strap_s = {s_reg.strap_s[0], act_strap_pin};
        s_next.amb_s = {s_reg.amb_s[0], auto_maint_loopback};
        s_next.tlc_s = {s_reg.tlc_s[0], transparent_loopback_ctrl};
        s_next.aact_s = {s_reg.aact_s[0], auto_activation};
        s_next.req_s = {s_reg.req_s[0], loopback_request};
        s_next.uact_s = {s_reg.uact_s[0], u_active};
        s_next.tone_s = {s_reg.tone_s[0], u_tone_rx};
        s_next.i1_s = {s_reg.i1_s[0], info1_rx};
        s_next.i3_s = {s_reg.i3_s[0], info3_rx};
        s_next.ltact_s = {s_reg.ltact_s[0], lt_act_rx};
        s_next.aact_d = s_reg.aact_s[1];

        acc = wb_cyc_i && wb_stb_i && !s_reg.ack;
        wr_ctrl = acc && wb_we_i && wb_sel_i[0] && (wb_adr_i[7:0] == stal_pkg::STAL_GLOBAL_CTRL_ADR);

        // loopback 2 entry on request, with auto loopback set or software loop control at 0
        loop_entered = s_reg.req_s[1] && (s_reg.amb_s[1] || !s_reg.tlc_s[1]); // [RL2] [RL3]
        s_next.loop_on = loop_entered;
        release_loop = s_reg.loop_on && !loop_entered;

        // strap sampled once after reset release through the synchroniser
        if (s_reg.strap_pending) begin
            s_next.act_sel = s_reg.strap_s[1]; // [RL7]
            s_next.strap_pending = 1'b0;
        end

        // info 3 as seen during the loop is our own looped signal
        if (!s_reg.loop_on) begin
            s_next.info3_seen = 1'b0;
            s_next.lt_act_seen = 1'b0;
        end else begin
            s_next.info3_seen = s_reg.info3_seen | 1'b1; // [RL6]
            if (s_reg.ltact_s[1]) begin
                s_next.lt_act_seen = 1'b1;
            end
        end

        // act bit toward lt
        if (s_reg.loop_on) begin
            s_next.act_tx = s_reg.act_sel && s_reg.info3_seen; // [RL1] [RL8] [RL9]
        end else begin
            s_next.act_tx = 1'b0;
        end

        // 2b+d toward lt
        if (s_reg.loop_on && s_reg.act_sel && !s_reg.lt_act_seen) begin
            s_next.utx = stal_pkg::STAL_ALL_ONES; // [RL10] [RL11]
        end else if (s_reg.loop_on) begin
            s_next.utx = u_rx_data; // [RL8]
        end else begin
            s_next.utx = st_rx_data;
        end

        // register writes
        if (wr_ctrl) begin
            s_next.low = wb_dat_i[5:0];
            if (!s_reg.strap_pending) begin
                s_next.act_sel = wb_dat_i[stal_pkg::STAL_BIT_ACT_SEL];
            end
            s_next.st_only = wb_dat_i[stal_pkg::STAL_BIT_ST_ONLY];
        end
        hw_set = s_reg.tone_s[1] || s_reg.i1_s[1] || s_reg.i3_s[1]; // [RL14]
        hw_set = hw_set || (s_reg.aact_d && !s_reg.aact_s[1]); // [RL15]
        if (hw_set || release_loop) begin
            s_next.st_only = hw_set ? 1'b1 : s_next.st_only; // [RL17]
        end

        // wishbone: single-cycle ack, unmapped reads zero
        s_next.ack = acc;
        s_next.rdata = stal_pkg::STAL_UNMAPPED_DATA;
        if (acc && !wb_we_i) begin
            if (wb_adr_i[7:0] == stal_pkg::STAL_GLOBAL_CTRL_ADR) begin
                s_next.rdata = {24'h000000, s_reg.st_only, s_reg.act_sel, s_reg.low};
            end else if (wb_adr_i[7:0] == stal_pkg::STAL_LOOP_STATUS_ADR) begin
                s_next.rdata = {28'h0000000, s_reg.lt_act_seen, s_reg.info3_seen, s_reg.act_tx, s_reg.loop_on};
            end
        end
    end

    // ==========================================================
    // register
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_reg <= '0;
            // strap synchroniser keeps sampling so the pin level is ready at release
            s_reg.strap_s <= s_next.strap_s; // [RL7]
            s_reg.strap_pending <= 1'b1;
            s_reg.st_only <= stal_pkg::STAL_ST_ONLY_RESET; // [RL16]
            s_reg.low <= stal_pkg::STAL_CTRL_LOW_RESET[5:0];
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // outputs
    always_comb begin
        st_rx_to_core = s_reg.loop_on ? st_tx_line : st_rx_line; // [RL4] [RL5]
        info3_report = s_reg.loop_on ? 1'b1 : s_reg.i3_s[1]; // [RL6]
        st_only_act_req = !s_reg.st_only && !s_reg.uact_s[1]; // [RL12] [RL13] [RL16]
    end
    assign wb_ack_o = s_reg.ack;
    assign wb_dat_o = s_reg.rdata;
    assign loopback2_active = s_reg.loop_on;
    assign act_bit_tx = s_reg.act_tx;
    assign u_tx_data = s_reg.utx;
    assign ctrl_low_bits = s_reg.low;
endmodule

//--- design/stal_pkg.sv
// Purpose: constants for the s/t activation and loopback control bank
// Assumes: 40 MHz mclk, classic wishbone slave with 8-bit data in the low lanes
// Notes: register index 0x02 maps to byte address 0x08
package stal_pkg;
    localparam logic [7:0] STAL_GLOBAL_CTRL_IDX = 8'h02;
    localparam logic [7:0] STAL_GLOBAL_CTRL_ADR = 8'h08;
    localparam logic [7:0] STAL_LOOP_STATUS_ADR = 8'h0c;
    localparam int STAL_BIT_ACT_SEL = 6;
    localparam int STAL_BIT_ST_ONLY = 7;
    localparam logic [7:0] STAL_CTRL_LOW_RESET = 8'h3f;
    localparam logic STAL_ST_ONLY_RESET = 1'b1;
    localparam logic [7:0] STAL_ALL_ONES = 8'hff;
    localparam logic [31:0] STAL_UNMAPPED_DATA = 32'h0000_0000;
endpackage

//--- tb/stal_line_model.sv
// Purpose: line termination and terminal side stand-in
// Assumes: lt_go commands the lt activation bit
// Notes: fixed data bytes, te line toggles
`timescale 1ns/1ps
module stal_line_model (
    input wire logic mclk,
    input wire logic lt_go,
    output logic lt_act_rx = 1'b0,
    output logic st_rx_line,
    output logic [7:0] u_rx_data,
    output logic [7:0] st_rx_data
);
    logic [1:0] phase_reg = 2'h0;
    assign u_rx_data = 8'h3c;
    assign st_rx_data = 8'hc3;
    assign st_rx_line = phase_reg[1];
    always @(posedge mclk) begin
        phase_reg <= phase_reg + 2'h1;
        lt_act_rx <= lt_go;
    end
endmodule

//--- tb/stal_ctrl_checker.sv
// Purpose: port checks for stal_ctrl
// Assumes: one mclk domain, sync reset
// Notes: bound at the foot
`timescale 1ns/1ps
module stal_ctrl_checker (
    input wire logic mclk, reset, wb_cyc_i, wb_stb_i, wb_ack_o, loopback_request, auto_maint_loopback,
    input wire logic [31:0] wb_dat_o,
    input wire logic u_active, st_tx_line, st_rx_to_core, info3_report, loopback2_active, act_bit_tx,
    input wire logic st_only_act_req
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    chk_ack_one_cycle: assert property ($rose(wb_ack_o) |=> !wb_ack_o) else $error("ack too long");
    chk_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    chk_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
    chk_loop_rx_mux: assert property (loopback2_active |-> st_rx_to_core == st_tx_line)
        else $error("receiver not looped");
    chk_loop_info3: assert property (loopback2_active |-> info3_report) else $error("no info3");
    chk_u_ignore: assert property (u_active [*3] |-> !st_only_act_req) else $error("st only with u");
    chk_loop_enter: assert property ((loopback_request && auto_maint_loopback) [*5] |-> loopback2_active)
        else $error("loop not entered");
    chk_act_late: assert property ($rose(loopback2_active) |-> !act_bit_tx) else $error("act early");
    cover property ($rose(loopback2_active));
    cover property ($rose(st_only_act_req));
    cover property ($rose(act_bit_tx));
endmodule
bind stal_ctrl stal_ctrl_checker u_chk (.mclk, .reset, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .loopback_request,
    .auto_maint_loopback, .wb_dat_o, .u_active, .st_tx_line, .st_rx_to_core, .info3_report,
    .loopback2_active, .act_bit_tx, .st_only_act_req);

//--- tb/stal_ctrl_bench.sv
// Purpose: scenario bench for stal_ctrl
// Assumes: strap high at reset, wishbone classic master
// Notes: waits are bounded
`timescale 1ns/1ps
module stal_ctrl_bench;
    logic mclk = 0, reset = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_ack_o, st_tx_line = 0, lt_go = 0;
    logic [31:0] wb_adr_i = 0, wb_dat_i = 0, wb_dat_o, rd;
    logic [3:0] wb_sel_i = 4'h1;
    logic act_strap_pin = 1, auto_maint_loopback = 0, transparent_loopback_ctrl = 1, auto_activation = 0;
    logic loopback_request = 0, u_active = 0, u_tone_rx = 0, info1_rx = 0, info3_rx = 0, lt_act_rx, st_rx_line;
    logic st_rx_to_core, info3_report, loopback2_active, act_bit_tx, st_only_act_req;
    logic [7:0] u_rx_data, st_rx_data, u_tx_data;
    logic [5:0] ctrl_low_bits;
    int failures = 0, checked = 0;
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) st_tx_line <= ~st_tx_line;
    stal_line_model u_line (.mclk, .lt_go, .lt_act_rx, .st_rx_line, .u_rx_data, .st_rx_data);
    stal_ctrl u_dut (.mclk, .reset, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i,
        .wb_ack_o, .act_strap_pin, .auto_maint_loopback, .transparent_loopback_ctrl, .auto_activation,
        .loopback_request, .u_active, .u_tone_rx, .info1_rx, .info3_rx, .lt_act_rx, .st_tx_line, .st_rx_line,
        .u_rx_data, .st_rx_data, .st_rx_to_core, .info3_report, .loopback2_active, .act_bit_tx, .u_tx_data,
        .st_only_act_req, .ctrl_low_bits);
    task automatic end_of_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic [7:0] adr, input logic we, input logic [7:0] dat);
        int n;
        n = 0;
        @(posedge mclk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        wb_adr_i <= {24'h0, adr};
        wb_dat_i <= {24'h0, dat};
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
        if (wb_ack_o !== 1'b1) begin
            failures++;
            end_of_test();
        end
    endtask
    task automatic wait_loop(input logic want);
        repeat (20) if (loopback2_active !== want) @(negedge mclk);
        check("loop_on", {31'h0, loopback2_active}, {31'h0, want});
        if (loopback2_active !== want) end_of_test();
    endtask
    task automatic t_reset_map();
        bus(stal_pkg::STAL_GLOBAL_CTRL_ADR, 0, 8'h00);
        check("ctrl_reset", rd, 32'hff);
        check("low_bits", {26'h0, ctrl_low_bits}, 32'h3f);
        check("u_tx_idle", {24'h0, u_tx_data}, 32'hc3);
        bus(8'h20, 1, 8'h00);
        bus(8'h20, 0, 8'h00);
        check("unmapped", rd, 32'h0);
    endtask
    task automatic t_st_only();
        for (int i = 0; i < 4; i++) begin
            bus(stal_pkg::STAL_GLOBAL_CTRL_ADR, 1, 8'h7f);
            repeat (4) @(negedge mclk);
            if (i == 0) check("st_req", {31'h0, st_only_act_req}, 32'h1);
            @(posedge mclk);
            if (i < 3) {u_tone_rx, info1_rx, info3_rx} <= 3'b100 >> i;
            else auto_activation <= 1;
            repeat (4) @(posedge mclk);
            {u_tone_rx, info1_rx, info3_rx, auto_activation} <= 4'h0;
            repeat (4) @(posedge mclk);
            bus(stal_pkg::STAL_GLOBAL_CTRL_ADR, 0, 8'h00);
            check("st_set", rd, 32'hff);
        end
        u_tone_rx <= 1;
        repeat (4) @(posedge mclk);
        bus(stal_pkg::STAL_GLOBAL_CTRL_ADR, 1, 8'h7f);
        bus(stal_pkg::STAL_GLOBAL_CTRL_ADR, 0, 8'h00);
        check("st_collide", rd, 32'hff);
        u_tone_rx <= 0;
        repeat (4) @(posedge mclk);
        bus(stal_pkg::STAL_GLOBAL_CTRL_ADR, 1, 8'h7f);
        u_active <= 1;
        repeat (5) @(negedge mclk);
        check("st_req_u", {31'h0, st_only_act_req}, 32'h0);
        @(posedge mclk) u_active <= 0;
    endtask
    task automatic t_loop(input logic sel);
        bus(stal_pkg::STAL_GLOBAL_CTRL_ADR, 1, {1'b1, sel, 6'h3f});
        auto_maint_loopback <= sel;
        transparent_loopback_ctrl <= sel;
        loopback_request <= 1;
        wait_loop(1);
        repeat (4) @(negedge mclk);
        check("info3", {31'h0, info3_report}, 32'h1);
        check("act_tx", {31'h0, act_bit_tx}, {31'h0, sel});
        check("u_tx", {24'h0, u_tx_data}, sel ? 32'hff : 32'h3c);
        @(posedge mclk) lt_go <= 1;
        repeat (8) @(negedge mclk);
        check("u_tx_lt", {24'h0, u_tx_data}, 32'h3c);
        @(posedge mclk) {loopback_request, lt_go, auto_maint_loopback, transparent_loopback_ctrl} <= 4'h1;
        wait_loop(0);
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        reset <= 0;
        repeat (3) @(posedge mclk);
        t_reset_map();
        t_st_only();
        t_loop(1);
        t_loop(0);
        end_of_test();
    end
endmodule
